/* design/vrpm_pkg.sv */
package vrpm_pkg;

	// Architectural vector registers per context
	localparam int ARCH_REGS = 32;
	// Default number of hardware thread contexts
	localparam int DEF_CTX = 4;
	// Default number of physical vector registers
	localparam int DEF_PHYS = 64;
	// Largest context count the address map can hold
	localparam int MAX_CTX = 8;

	// Avalon byte address and data widths
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;

	// Per-context register offsets inside one context window
	localparam logic [4:0] OFS_GRANT = 5'h00;
	localparam logic [4:0] OFS_RELEASE = 5'h04;
	localparam logic [4:0] OFS_ACCESS = 5'h08;
	localparam logic [4:0] OFS_SAVE = 5'h0C;
	localparam logic [4:0] OFS_MODIFY = 5'h10;
	localparam logic [4:0] OFS_REQUEST = 5'h14;
	// Context window select field: address bits [7:5]
	localparam int CTX_LSB = 5;
	// Address bit 8 selects the global window
	localparam int GLOBAL_BIT = 8;
	// Global interrupt registers
	localparam logic [4:0] OFS_IRQ_STAT = 5'h00;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h04;

	// Reset value of every control bit set
	localparam logic [31:0] RST_BITS = 32'h0000_0000;

	// Interrupt event bit positions
	localparam int EV_FAULT = 0;
	localparam int EV_GRANT_FAIL = 1;
	localparam int IRQ_W = 2;
	localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

	// Bus handshake states
	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b00,
		BUS_ACK = 2'b01
	} vrpm_bus_t;

	// One vector instruction's register use
	typedef struct packed
	{
		logic valid; // Instruction issued this cycle
		logic [2:0] ctx; // Issuing hardware context
		logic [31:0] rdMask; // Architectural registers read
		logic [31:0] wrMask; // Architectural registers written
		logic [4:0] dstIdx; // Register whose storage is looked up
	} vrpm_inst_t;

endpackage : vrpm_pkg

/* design/vrpm_top.sv */
`timescale 1ns/1ps
// Contract
// RQ1: Table maps each physical register to owner
// RQ2: Every context has its own control state
// RQ3: Grant write binds a free physical register
// RQ4: Access bit n set when register mapped
// RQ5: Failed grant leaves access and table unchanged
// RQ6: Software reads access back after grant
// RQ7: Unmapped or pending-save use raises fault
// RQ8: Fault sets request bit of each culprit
// RQ9: Any register write sets its modified bit
// RQ10: Software may clear pending-save bits
// RQ11: Software may clear modified bits
// RQ12: Software sets save bits on thread switch
// RQ13: Save equal access makes switch safe
// RQ14: Software saves then releases before moving
// RQ15: Release write frees the bound physical register
// RQ16: Freed register serves any later grant
// RQ17: Same context and index reach same storage
// RQ18: Release also clears the access bit
module vrpm_top
	import vrpm_pkg::*;
#(
	parameter int NCTX = DEF_CTX, // Hardware thread contexts
	parameter int NPHYS = DEF_PHYS // Physical vector registers
)
(
	input wire logic core_clk, // Core clock, 10 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [ADDR_W-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [DATA_W-1:0] avs_writedata, // Write data
	output logic [DATA_W-1:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall until answer
	input wire vrpm_inst_t inst, // Instruction register use
	output logic instFault, // Access-disabled exception pulse
	output logic [$clog2(NPHYS)-1:0] instPhys, // Storage of dstIdx
	output logic instPhysOk, // dstIdx is mapped
	output logic irq // Level interrupt
);

	localparam int PHW = $clog2(NPHYS);
	// Refuse sizes the address map or table cannot serve
	if (NCTX < 2 || NCTX > MAX_CTX || NPHYS < 2)
	begin : g_bad_size
		$error("NCTX must lie between 2 and 8, NPHYS at least 2");
	end
	// Mapping table, one entry per physical register
	logic [NPHYS-1:0] tblValid; // Entry bound
	logic [NPHYS-1:0][2:0] tblCtx; // Owning context
	logic [NPHYS-1:0][4:0] tblArch; // Backed architectural index
	// Per-context control state
	logic [NCTX-1:0][31:0] accessReg; // Mapped registers
	logic [NCTX-1:0][31:0] saveReg; // Pending-save registers
	logic [NCTX-1:0][31:0] modifyReg; // Written registers
	logic [NCTX-1:0][31:0] requestReg; // Fault culprits
	// Interrupt state
	logic [IRQ_W-1:0] irqStatReg; // Sticky events
	logic [IRQ_W-1:0] irqMaskReg; // Enables
	logic [IRQ_W-1:0] irqStatNext; // Status after events and clears
	// Bus handshake
	vrpm_bus_t busState; // Idle or answering
	logic waitReqReg; // Drives waitrequest
	logic [DATA_W-1:0] readDataReg; // Drives readdata
	logic busReq; // A request is present
	logic commit; // Request completes this edge
	logic [2:0] bCtx; // Addressed context
	logic [4:0] bOfs; // Offset inside window
	logic bGlobal; // Global window addressed
	logic ctxOk; // Addressed context exists
	logic [DATA_W-1:0] rdValue; // Value for a read
	logic [4:0] wIdx; // Written architectural index
	// Decoded register writes
	logic grantHit, releaseHit, saveWr, modifyWr, requestWr;
	logic irqStatWr, irqMaskWr;
	// Table searches
	logic freeFound; // Some entry is free
	logic [PHW-1:0] freeIdx; // Lowest free entry
	logic mapped; // Bus context already holds wIdx
	logic [PHW-1:0] mapIdx; // Entry holding it
	logic instMapped; // Instruction context holds dstIdx
	logic [PHW-1:0] instIdx; // Entry holding it
	// Instruction checks
	logic instCtxOk; // Instruction context exists
	logic [31:0] faultBits; // Registers that block the access
	logic faultEv; // Access-disabled event
	logic writeOk; // Access completes and writes
	logic grantFail; // Grant found no free entry
	assign busReq = avs_read | avs_write;
	assign commit = busReq & ~waitReqReg;
	assign bCtx = avs_address[CTX_LSB+2:CTX_LSB];
	assign bOfs = avs_address[4:0];
	assign bGlobal = avs_address[GLOBAL_BIT];
	assign ctxOk = (32'(bCtx) < NCTX);
	assign wIdx = avs_writedata[4:0];
	// Write decode, effective only on the completing edge
	always_comb
	begin
		grantHit = 1'b0;
		releaseHit = 1'b0;
		saveWr = 1'b0;
		modifyWr = 1'b0;
		requestWr = 1'b0;
		irqStatWr = 1'b0;
		irqMaskWr = 1'b0;
		if (commit && avs_write && bGlobal)
		begin
			irqStatWr = (bOfs == OFS_IRQ_STAT);
			irqMaskWr = (bOfs == OFS_IRQ_MASK);
		end
		else if (commit && avs_write && ctxOk)
		begin
			grantHit = (bOfs == OFS_GRANT);
			releaseHit = (bOfs == OFS_RELEASE);
			saveWr = (bOfs == OFS_SAVE);
			modifyWr = (bOfs == OFS_MODIFY);
			requestWr = (bOfs == OFS_REQUEST);
		end
	end

	// Read mux; unmapped addresses read as zero
	always_comb
	begin
		rdValue = '0;
		if (bGlobal)
		begin
			case (bOfs)
				OFS_IRQ_STAT: rdValue = 32'(irqStatReg);
				OFS_IRQ_MASK: rdValue = 32'(irqMaskReg);
				default: rdValue = '0;
			endcase
		end
		else if (ctxOk)
		begin
			case (bOfs)
				OFS_ACCESS: rdValue = accessReg[bCtx]; // [RQ4]
				OFS_SAVE: rdValue = saveReg[bCtx];
				OFS_MODIFY: rdValue = modifyReg[bCtx];
				OFS_REQUEST: rdValue = requestReg[bCtx];
				default: rdValue = '0;
			endcase
		end
	end

	// Bus handshake: one stall cycle, then one answer cycle
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busState <= BUS_IDLE;
			waitReqReg <= 1'b1;
			readDataReg <= '0;
		end
		else
		begin
			case (busState)
				BUS_IDLE:
				begin
					if (busReq)
					begin
						busState <= BUS_ACK;
						waitReqReg <= 1'b0;
						readDataReg <= avs_read ? rdValue : '0;
					end
				end
				default: // Answer cycle or stray code back to idle
				begin
					busState <= BUS_IDLE;
					waitReqReg <= 1'b1;
				end
			endcase
		end
	end

	// Table searches: free entry, bus binding, instruction binding
	always_comb
	begin
		freeFound = 1'b0;
		freeIdx = '0;
		mapped = 1'b0;
		mapIdx = '0;
		instMapped = 1'b0;
		instIdx = '0;
		for (int p = NPHYS - 1; p >= 0; p--)
		begin
			if (!tblValid[p])
			begin
				freeFound = 1'b1; // [RQ16]
				freeIdx = PHW'(p);
			end
			if (tblValid[p] && tblCtx[p] == bCtx && tblArch[p] == wIdx)
			begin
				mapped = 1'b1;
				mapIdx = PHW'(p);
			end
			if (tblValid[p] && tblCtx[p] == inst.ctx &&
				tblArch[p] == inst.dstIdx)
			begin
				instMapped = 1'b1; // [RQ17]
				instIdx = PHW'(p);
			end
		end
	end

	assign grantFail = grantHit & ~mapped & ~freeFound; // [RQ5]

	// Table update on grant and release
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tblValid <= '0;
			tblCtx <= '0;
			tblArch <= '0;
		end
		else if (grantHit && !mapped && freeFound)
		begin
			tblValid[freeIdx] <= 1'b1; // [RQ1] [RQ3] [RQ16]
			tblCtx[freeIdx] <= bCtx;
			tblArch[freeIdx] <= wIdx;
		end
		else if (releaseHit && mapped)
		begin
			tblValid[mapIdx] <= 1'b0; // [RQ15]
		end
	end

	// Instruction check against access and pending-save bits
	assign instCtxOk = (32'(inst.ctx) < NCTX);
	assign faultBits = instCtxOk ?
		((inst.rdMask | inst.wrMask) &
		(saveReg[inst.ctx] | ~accessReg[inst.ctx])) : '0; // [RQ7] [RQ13]
	assign faultEv = inst.valid & instCtxOk & (|faultBits);
	assign writeOk = inst.valid & instCtxOk & ~(|faultBits);

	// Per-context control state, each context independent
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			accessReg <= {NCTX{RST_BITS}};
			saveReg <= {NCTX{RST_BITS}};
			modifyReg <= {NCTX{RST_BITS}};
			requestReg <= {NCTX{RST_BITS}};
		end
		else
		begin
			for (int c = 0; c < NCTX; c++)
			begin
				// Grant sets, release clears, only for bus context
				if (grantHit && bCtx == 3'(c) && (mapped || freeFound))
					accessReg[c][wIdx] <= 1'b1; // [RQ2] [RQ3] [RQ4]
				else if (releaseHit && bCtx == 3'(c))
					accessReg[c][wIdx] <= 1'b0; // [RQ18]
				// Pending-save bits are plain read/write
				if (saveWr && bCtx == 3'(c))
					saveReg[c] <= avs_writedata; // [RQ10] [RQ13]
				// Modified bits: write one clears, hardware set wins
				modifyReg[c] <= (modifyReg[c] &
					~((modifyWr && bCtx == 3'(c)) ? avs_writedata : '0)) |
					((writeOk && inst.ctx == 3'(c)) ?
					inst.wrMask : '0); // [RQ9] [RQ11]
				// Request bits: write one clears, fault set wins
				requestReg[c] <= (requestReg[c] &
					~((requestWr && bCtx == 3'(c)) ? avs_writedata : '0)) |
					((faultEv && inst.ctx == 3'(c)) ?
					faultBits : '0); // [RQ8]
			end
		end
	end

	// Instruction answers: fault pulse and storage index
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			instFault <= 1'b0;
			instPhys <= '0;
			instPhysOk <= 1'b0;
		end
		else
		begin
			instFault <= faultEv; // [RQ7]
			instPhys <= instIdx; // [RQ17]
			instPhysOk <= inst.valid & instCtxOk & instMapped;
		end
	end

	// Sticky events: write one clears, new event wins
	always_comb
	begin
		irqStatNext = irqStatReg &
			~(irqStatWr ? avs_writedata[IRQ_W-1:0] : RST_IRQ);
		irqStatNext[EV_FAULT] = irqStatNext[EV_FAULT] | faultEv;
		irqStatNext[EV_GRANT_FAIL] = irqStatNext[EV_GRANT_FAIL] | grantFail;
	end

	// Interrupt status, mask and level output
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irqStatReg <= RST_IRQ;
			irqMaskReg <= RST_IRQ;
			irq <= 1'b0;
		end
		else
		begin
			irqStatReg <= irqStatNext;
			if (irqMaskWr)
				irqMaskReg <= avs_writedata[IRQ_W-1:0];
			irq <= |(irqStatReg & irqMaskReg);
		end
	end
	assign avs_waitrequest = waitReqReg;
	assign avs_readdata = readDataReg;
	// Grant sets the access bit of the granted index
	a_grant_sets_access: assert property ( // [RQ3] [RQ4]
		@(posedge core_clk) disable iff (!rst_n)
		grantHit && (mapped || freeFound) |=>
		accessReg[$past(bCtx)][$past(wIdx)])
		else $error("grant did not set access bit");
	// Failed grant changes neither access nor table
	a_grant_full_keeps: assert property ( // [RQ5]
		@(posedge core_clk) disable iff (!rst_n)
		grantFail && !releaseHit |=> $stable(accessReg) && $stable(tblValid))
		else $error("failed grant changed state");
	// Regrant of a held index keeps the same entry
	a_regrant_same_entry: assert property ( // [RQ17]
		@(posedge core_clk) disable iff (!rst_n)
		grantHit && mapped |=> $stable(tblValid) && $stable(tblArch))
		else $error("regrant moved the binding");
	// Release frees the entry and clears access
	a_release_frees: assert property ( // [RQ15] [RQ18]
		@(posedge core_clk) disable iff (!rst_n)
		releaseHit && mapped |=> !tblValid[$past(mapIdx)] &&
		!accessReg[$past(bCtx)][$past(wIdx)])
		else $error("release left entry or access bit");
	// Blocked access raises the fault pulse next cycle
	a_fault_pulse: assert property ( // [RQ7]
		@(posedge core_clk) disable iff (!rst_n)
		inst.valid && instCtxOk && (|faultBits) |=> instFault)
		else $error("blocked access raised no fault");
	// Fault records every culprit register
	a_fault_request: assert property ( // [RQ8]
		@(posedge core_clk) disable iff (!rst_n)
		faultEv |=> (requestReg[$past(inst.ctx)] & $past(faultBits))
		== $past(faultBits))
		else $error("fault culprits not recorded");
	// Completed write marks the written registers modified
	a_write_modify: assert property ( // [RQ9]
		@(posedge core_clk) disable iff (!rst_n)
		writeOk |=> (modifyReg[$past(inst.ctx)] & $past(inst.wrMask))
		== $past(inst.wrMask))
		else $error("written register not modified");
	// Unmasked fault event raises the interrupt
	a_irq_level: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		faultEv && irqMaskReg[EV_FAULT] |=> ##1 irq)
		else $error("interrupt did not rise");
	// Request is answered after exactly one stall cycle
	a_bus_answer: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		busReq && waitReqReg |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");
endmodule : vrpm_top

/* bench/vrpm_thread_model.sv */
`timescale 1ns/1ps
// Hardware thread context issuing vector instructions
module vrpm_thread_model
	import vrpm_pkg::*;
(
	input wire logic core_clk, // Core clock
	output vrpm_inst_t inst // Register use of one instruction
);
	// Idle from time zero
	initial inst = '0;
	// Issue one instruction at the next edge
	task issue(input logic [2:0] c, input logic [31:0] r,
		input logic [31:0] w, input logic [4:0] d);
		@(posedge core_clk);
		inst <= '{1'b1, c, r, w, d};
	endtask : issue
	// Drop valid; other fields toggle so stale values never look settled
	task idle();
		@(posedge core_clk);
		inst <= '{1'b0, ~inst.ctx, ~inst.rdMask, ~inst.wrMask, ~inst.dstIdx};
	endtask : idle
endmodule : vrpm_thread_model

/* bench/vrpm_top_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the register partition allocator
module vrpm_top_tb
	import vrpm_pkg::*;
();
	localparam int NP = 4; // Small pool so exhaustion is reachable
	logic core_clk = 1'b0; // Core clock
	logic rst_n = 1'b0; // Reset, active low
	logic [ADDR_W-1:0] avs_address = '0; // Bus address
	logic avs_read = 1'b0; // Bus read
	logic avs_write = 1'b0; // Bus write
	logic [DATA_W-1:0] avs_writedata = '0; // Bus write data
	logic [DATA_W-1:0] avs_readdata; // Bus read data
	logic avs_waitrequest; // Bus stall
	vrpm_inst_t inst; // Instruction from the model
	logic instFault; // Exception pulse
	logic [$clog2(NP)-1:0] instPhys; // Looked-up entry
	logic instPhysOk; // Lookup valid
	logic irq; // Interrupt
	int failures = 0; // Mismatch count
	int tests_run = 0; // Comparison count
	integer seed = 32'haf73856b; // Random seed
	logic [31:0] rdQ[$]; // Expected read data
	logic [8:0] instQ[$]; // Expected fault, ok, entry
	logic pendInst = 1'b0; // Instruction answer due
	logic [31:0] acc, sav, modx, r, w; // Shadow of context 0
	logic [8:0] e; // Popped note
	logic f; // Expected fault
	int d; // Random destination

	// 10 MHz clock
	always #50 core_clk = ~core_clk;

	vrpm_top #(.NCTX(DEF_CTX), .NPHYS(NP)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .inst(inst),
		.instFault(instFault), .instPhys(instPhys),
		.instPhysOk(instPhysOk), .irq(irq));
	vrpm_thread_model th (.core_clk(core_clk), .inst(inst));

	// Compare and count
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		tests_run++;
		if (got !== ex)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	// Print counts and verdict
	task complete_run();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	// Context window address
	function logic [8:0] ad(input int c, input logic [4:0] o);
		return 9'(c * 32) | 9'(o);
	endfunction : ad

	// One Avalon transfer, held until waitrequest is seen low
	task bus(input logic wr, input logic [8:0] a, input logic [31:0] dt);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= dt;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0);
		// One stall edge, then the answering edge
		chk("wait cycles", 32'h2, 32'(n));
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	// Read with expectation noted for the monitor
	task br(input logic [8:0] a, input logic [31:0] ex);
		rdQ.push_back(ex);
		bus(1'b0, a, '0);
	endtask : br

	// Write
	task bw(input logic [8:0] a, input logic [31:0] dt);
		bus(1'b1, a, dt);
	endtask : bw

	// Instruction with expected fault, lookup flag and entry
	task ins(input int c, input logic [31:0] rm, input logic [31:0] wm,
		input int di, input logic xf, input logic xo, input int xp);
		instQ.push_back({xf, xo, 7'(xp)});
		th.issue(3'(c), rm, wm, 5'(di));
	endtask : ins

	// Monitor: takes oldest note whenever an answer stands
	always @(posedge core_clk)
	begin
		pendInst <= inst.valid;
		if (avs_read && !avs_waitrequest)
			chk("readdata", rdQ.pop_front(), avs_readdata);
		if (pendInst)
		begin
			e = instQ.pop_front();
			chk("fault", 32'(e[8]), 32'(instFault));
			chk("physOk", 32'(e[7]), 32'(instPhysOk));
			if (e[7])
				chk("phys", 32'(e[6:0]), 32'(instPhys));
		end
	end

	// Watchdog
	initial
	begin
		repeat (5000) @(posedge core_clk);
		failures++;
		complete_run();
	end

	// Main sequence
	initial
	begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		// Reset values and an unmapped offset
		for (int o = 8; o <= 24; o += 4)
			br(ad(0, 5'(o)), RST_BITS);
		br(9'h100, '0);
		br(9'h104, '0);
		$display("test reset done");
		// Grants on context 0, context 1 untouched
		bw(ad(0, OFS_GRANT), 32'h2);
		br(ad(0, OFS_ACCESS), 32'h4);
		bw(ad(0, OFS_GRANT), 32'h1);
		br(ad(0, OFS_ACCESS), 32'h6);
		br(ad(1, OFS_ACCESS), 32'h0);
		ins(0, 32'h2, 32'h4, 2, 0, 1, 0);
		ins(0, 32'h2, 32'h4, 1, 0, 1, 1);
		th.idle();
		br(ad(0, OFS_MODIFY), 32'h4);
		$display("test grant done");
		// Thread switch: save set equal to access
		bw(ad(0, OFS_SAVE), 32'h6);
		ins(0, 32'h8, 32'h4, 2, 1, 1, 0);
		th.idle();
		br(ad(0, OFS_REQUEST), 32'hC);
		br(9'h100, 32'h1);
		chk("irq masked", '0, 32'(irq));
		bw(9'h104, 32'h1);
		repeat (2) @(posedge core_clk);
		chk("irq raised", 32'h1, 32'(irq));
		bw(9'h100, 32'h1);
		repeat (2) @(posedge core_clk);
		chk("irq cleared", '0, 32'(irq));
		bw(ad(0, OFS_SAVE), 32'h2);
		bw(ad(0, OFS_MODIFY), 32'h4);
		bw(ad(0, OFS_REQUEST), 32'hC);
		br(ad(0, OFS_SAVE), 32'h2);
		br(ad(0, OFS_MODIFY), 32'h0);
		br(ad(0, OFS_REQUEST), 32'h0);
		$display("test switch done");
		// Release after save, entry reused by another context
		bw(ad(0, OFS_RELEASE), 32'h2);
		br(ad(0, OFS_ACCESS), 32'h2);
		ins(0, 32'h0, 32'h4, 2, 1, 0, 0);
		th.idle();
		bw(ad(1, OFS_GRANT), 32'h9);
		ins(1, 32'h200, 32'h0, 9, 0, 1, 0);
		th.idle();
		// Fill the pool; the last grant is refused
		bw(ad(1, OFS_GRANT), 32'h3);
		bw(ad(1, OFS_GRANT), 32'h4);
		bw(9'h100, 32'h3);
		bw(ad(1, OFS_GRANT), 32'h5);
		br(ad(1, OFS_ACCESS), 32'h218);
		br(9'h100, 32'h2);
		// W1 is still pending save: the use faults, binding kept
		ins(0, 32'h2, 32'h0, 1, 1, 1, 1);
		th.idle();
		$display("test release done");
		// Random register use on context 0
		acc = 32'h2;
		sav = $random(seed) & 32'h7;
		modx = '0;
		bw(ad(0, OFS_SAVE), sav);
		repeat (24)
		begin
			r = $random(seed) & 32'h7;
			w = $random(seed) & 32'h7;
			d = $random(seed) & 3;
			f = |((r | w) & (sav | ~acc));
			if (!f)
				modx = modx | w;
			ins(0, r, w, d, f, acc[d], 1);
		end
		th.idle();
		br(ad(0, OFS_MODIFY), modx);
		$display("test random done");
		complete_run();
	end
endmodule : vrpm_top_tb
